/* File: rtc_prescaler_counter_alarm.sv */
// Contract
// [R1] divider clocked by core clock over 64
// [R2] 20-bit divider reloads each reference period
// [R3] tick period is 64 times prescale value
// [R4] prescale high four bits, low sixteen bits
// [R5] 32-bit time count advances each tick
// [R6] alarm request when time equals alarm
// [R7] tick request possible every reference period
// [R8] switch-off stops counting, allows writes, oscillator
// [R9] alarm enable gates alarm request
// [R10] tick enable gates tick request
// [R11] flags set on events, write one clears
// [R12] prescale writes need switch-off set
// [R13] prescale registers survive reset
// [R14] prescale high reads zero above bit 3
// [R15] both requests routed to wake lines
// [R16] whole-register accesses only
// [R17] wake only with power-down wake config
// [R18] counters halt in stand-by mode
// [R19] time writes need switch-off, load directly
// [R20] requests are rising-edge pulses
// [R21] tick in same cycle as reload
// [R22] one alarm request per match
`timescale 1ns/1ps
module rtc_prescaler_counter_alarm
  import rtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] busAddr,         // register byte address
  input  wire logic        busWrite,        // word write strobe
  input  wire logic        busRead,         // word read strobe
  input  wire logic [15:0] busWdata,        // write data
  output logic      [15:0] busRdata_r,      // read data
  input  wire logic        powerDown,       // chip in power-down
  input  wire logic        standBy,         // chip in stand-by
  input  wire logic        powerdownWakeConfig, // wake allowed
  output logic             tickRequest_r,   // tick request pulse
  output logic             alarmRequest_r,  // alarm request pulse
  output logic             oscStop_r,       // oscillator off
  output logic             wakeRequest_r    // leave power-down
);

  // whole block state
  typedef struct packed {
    logic                  switchOff;    // stop and unlock
    logic                  alarmIrqEnable;
    logic                  alarmIrqFlag;
    logic                  tickIrqEnable;
    logic                  tickIrqFlag;
    logic [PRESCALE_W-1:0] prescaleValue; // not reset
    logic [TIME_W-1:0]     timeCount;     // not reset
    logic [TIME_W-1:0]     alarmValue;    // not reset
    logic                  matchPrev;     // match seen last cycle
    logic                  loadPending;   // divider preload
    logic [15:0]           busRdata;
    logic                  tickRequest;
    logic                  alarmRequest;
    logic                  oscStop;
    logic                  wakeRequest;
  } rtc_state_t;

  rtc_state_t             st_r;       // registered state
  rtc_state_t             st_nxt;     // next state
  logic                   tickPulse;  // basic reference tick
  logic [PRESCALE_W-1:0]  divCount;   // divider contents
  logic                   runCount;   // dividers may count
  logic                   matchNow;   // time equals alarm
  logic                   alarmEvent; // first cycle of a match

  // counting stops on switch-off and in stand-by
  assign runCount = !st_r.switchOff && !standBy; // [R8] [R18]

  // prescaler divider with its fixed pre-stage
  rtc_divider rtc_divider_i (
    .clk        (clk),
    .rst_n      (rst_n),
    .run        (runCount),
    .load       (st_r.loadPending),
    .prescale   (st_r.prescaleValue),
    .tickPulse  (tickPulse),
    .divCount_r (divCount)
  );

  // alarm compare and single-shot event
  assign matchNow   = (st_r.timeCount == st_r.alarmValue); // [R6]
  assign alarmEvent = matchNow && !st_r.matchPrev;         // [R22]

  // next state: counting, bus access, flags, requests
  always_comb begin
    st_nxt             = st_r;
    st_nxt.loadPending = 1'b0;
    st_nxt.matchPrev   = matchNow;
    // time count advance
    if (tickPulse) begin
      st_nxt.timeCount = st_r.timeCount + 32'h00000001; // [R5]
    end
    // whole-word register writes
    if (busWrite) begin // [R16]
      case (busAddr)
        ADDR_CLOCK_CONTROL: begin
          st_nxt.switchOff      = busWdata[SWITCH_OFF_BIT];
          st_nxt.alarmIrqEnable = busWdata[ALARM_EN_BIT];
          st_nxt.tickIrqEnable  = busWdata[TICK_EN_BIT];
          // write one clears a flag
          if (busWdata[ALARM_FLAG_BIT]) begin
            st_nxt.alarmIrqFlag = 1'b0; // [R11]
          end
          if (busWdata[TICK_FLAG_BIT]) begin
            st_nxt.tickIrqFlag = 1'b0; // [R11]
          end
        end
        ADDR_PRESCALE_LOW: begin
          // protected unless switched off
          if (st_r.switchOff) begin // [R12]
            st_nxt.prescaleValue[15:0] = busWdata; // [R4]
            st_nxt.loadPending         = 1'b1;
          end
        end
        ADDR_PRESCALE_HIGH: begin
          if (st_r.switchOff) begin // [R12]
            st_nxt.prescaleValue[PRESCALE_W-1:16] =
              busWdata[PRESCALE_HI_W-1:0]; // [R4]
            st_nxt.loadPending = 1'b1;
          end
        end
        ADDR_TIME_LOW: begin
          if (st_r.switchOff) begin // [R19]
            st_nxt.timeCount[15:0] = busWdata;
          end
        end
        ADDR_TIME_HIGH: begin
          if (st_r.switchOff) begin // [R19]
            st_nxt.timeCount[31:16] = busWdata;
          end
        end
        ADDR_ALARM_LOW: begin
          st_nxt.alarmValue[15:0] = busWdata;
        end
        ADDR_ALARM_HIGH: begin
          st_nxt.alarmValue[31:16] = busWdata;
        end
        default: begin
          // divider, unmapped: writes ignored
        end
      endcase
    end
    // hardware set wins over a clearing write
    if (tickPulse) begin
      st_nxt.tickIrqFlag = 1'b1; // [R11]
    end
    if (alarmEvent) begin
      st_nxt.alarmIrqFlag = 1'b1; // [R11]
    end
    // one-cycle requests, rising edge toward the port
    st_nxt.tickRequest  = tickPulse && st_r.tickIrqEnable; // [R7] [R10] [R20]
    st_nxt.alarmRequest = alarmEvent && st_r.alarmIrqEnable; // [R9] [R20]
    // oscillator off in power-down only when switched off
    st_nxt.oscStop = powerDown && st_r.switchOff; // [R8]
    // either request wakes the chip if configured
    st_nxt.wakeRequest = powerDown && powerdownWakeConfig && // [R17]
                         (st_nxt.tickRequest || st_nxt.alarmRequest); // [R15]
    // register reads
    if (busRead) begin
      case (busAddr)
        ADDR_CLOCK_CONTROL: begin
          st_nxt.busRdata = 16'h0000;
          st_nxt.busRdata[SWITCH_OFF_BIT] = st_r.switchOff;
          st_nxt.busRdata[ALARM_EN_BIT]   = st_r.alarmIrqEnable;
          st_nxt.busRdata[ALARM_FLAG_BIT] = st_r.alarmIrqFlag;
          st_nxt.busRdata[TICK_EN_BIT]    = st_r.tickIrqEnable;
          st_nxt.busRdata[TICK_FLAG_BIT]  = st_r.tickIrqFlag;
        end
        ADDR_PRESCALE_LOW: begin
          st_nxt.busRdata = st_r.prescaleValue[15:0];
        end
        ADDR_PRESCALE_HIGH: begin
          st_nxt.busRdata = {12'h000,
                             st_r.prescaleValue[PRESCALE_W-1:16]}; // [R14]
        end
        ADDR_DIVIDER_LOW: begin
          st_nxt.busRdata = divCount[15:0];
        end
        ADDR_DIVIDER_HIGH: begin
          st_nxt.busRdata = {12'h000, divCount[PRESCALE_W-1:16]};
        end
        ADDR_TIME_LOW: begin
          st_nxt.busRdata = st_r.timeCount[15:0];
        end
        ADDR_TIME_HIGH: begin
          st_nxt.busRdata = st_r.timeCount[31:16];
        end
        ADDR_ALARM_LOW: begin
          st_nxt.busRdata = st_r.alarmValue[15:0];
        end
        ADDR_ALARM_HIGH: begin
          st_nxt.busRdata = st_r.alarmValue[31:16];
        end
        default: begin
          st_nxt.busRdata = 16'h0000; // unmapped reads zero
        end
      endcase
    end
  end

  // registers; prescale, time and alarm keep value through reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.switchOff      <= CLOCK_CONTROL_RESET[SWITCH_OFF_BIT];
      st_r.alarmIrqEnable <= CLOCK_CONTROL_RESET[ALARM_EN_BIT];
      st_r.alarmIrqFlag   <= CLOCK_CONTROL_RESET[ALARM_FLAG_BIT];
      st_r.tickIrqEnable  <= CLOCK_CONTROL_RESET[TICK_EN_BIT];
      st_r.tickIrqFlag    <= CLOCK_CONTROL_RESET[TICK_FLAG_BIT];
      st_r.matchPrev      <= 1'b1; // no alarm straight out of reset
      st_r.loadPending    <= 1'b0;
      st_r.busRdata       <= 16'h0000;
      st_r.tickRequest    <= 1'b0;
      st_r.alarmRequest   <= 1'b0;
      st_r.oscStop        <= 1'b0;
      st_r.wakeRequest    <= 1'b0;
    end else begin
      st_r <= st_nxt; // [R13]
    end
  end

  // outputs straight from flops
  assign busRdata_r     = st_r.busRdata;
  assign tickRequest_r  = st_r.tickRequest;
  assign alarmRequest_r = st_r.alarmRequest;
  assign oscStop_r      = st_r.oscStop;
  assign wakeRequest_r  = st_r.wakeRequest;

  // enabled tick gives a request next cycle
  property p_tick_req;
    @(posedge clk) disable iff (!rst_n)
      (tickPulse && st_r.tickIrqEnable) |=> tickRequest_r;
  endproperty
  a_tick_req: assert property (p_tick_req) // [R10]
    else $error("enabled tick gave no request");

  // disabled tick gives no request
  property p_tick_off;
    @(posedge clk) disable iff (!rst_n)
      !st_r.tickIrqEnable |=> !tickRequest_r;
  endproperty
  a_tick_off: assert property (p_tick_off) // [R10]
    else $error("tick request while disabled");

  // enabled match gives alarm request
  property p_alarm_req;
    @(posedge clk) disable iff (!rst_n)
      (alarmEvent && st_r.alarmIrqEnable) |=> alarmRequest_r;
  endproperty
  a_alarm_req: assert property (p_alarm_req) // [R9]
    else $error("alarm match gave no request");

  // alarm request is a single pulse
  property p_alarm_once;
    @(posedge clk) disable iff (!rst_n)
      alarmRequest_r |=> !alarmRequest_r;
  endproperty
  a_alarm_once: assert property (p_alarm_once) // [R22]
    else $error("alarm request longer than one cycle");

  // tick sets its flag
  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
      tickPulse |=> st_r.tickIrqFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) // [R11]
    else $error("tick flag not set");

  // time advances by one on a tick
  property p_count;
    @(posedge clk) disable iff (!rst_n)
      tickPulse |=> st_r.timeCount == $past(st_r.timeCount) + 32'h00000001;
  endproperty
  a_count: assert property (p_count) // [R5]
    else $error("time count did not advance");

  // switched off: no tick, time only changes by a write
  property p_stopped;
    @(posedge clk) disable iff (!rst_n)
      (st_r.switchOff && !busWrite) |=> $stable(st_r.timeCount);
  endproperty
  a_stopped: assert property (p_stopped) // [R8]
    else $error("time count moved while switched off");

  // prescale locked while running
  property p_protect;
    @(posedge clk) disable iff (!rst_n)
      !st_r.switchOff |=> $stable(st_r.prescaleValue);
  endproperty
  a_protect: assert property (p_protect) // [R12]
    else $error("prescale changed while running");

  // high prescale reads zero in upper bits
  property p_high_zero;
    @(posedge clk) disable iff (!rst_n)
      (busRead && busAddr == ADDR_PRESCALE_HIGH) |=>
        busRdata_r[15:4] == 12'h000;
  endproperty
  a_high_zero: assert property (p_high_zero) // [R14]
    else $error("prescale high upper bits not zero");

  // wake needs the wake configuration
  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      !powerdownWakeConfig |=> !wakeRequest_r;
  endproperty
  a_wake: assert property (p_wake) // [R17]
    else $error("wake without wake configuration");

  // main scenarios
  c_tick:  cover property (@(posedge clk) disable iff (!rst_n) tickRequest_r);
  c_alarm: cover property (@(posedge clk) disable iff (!rst_n) alarmRequest_r);
  c_wake:  cover property (@(posedge clk) disable iff (!rst_n) wakeRequest_r);

endmodule : rtc_prescaler_counter_alarm

/* File: rtc_pkg.sv */
package rtc_pkg;
  // register byte addresses on the peripheral bus
  localparam logic [15:0] ADDR_CLOCK_CONTROL = 16'hED00;
  localparam logic [15:0] ADDR_PRESCALE_LOW  = 16'hED06;
  localparam logic [15:0] ADDR_PRESCALE_HIGH = 16'hED08;
  localparam logic [15:0] ADDR_DIVIDER_LOW   = 16'hED0A;
  localparam logic [15:0] ADDR_DIVIDER_HIGH  = 16'hED0C;
  localparam logic [15:0] ADDR_TIME_LOW      = 16'hED0E;
  localparam logic [15:0] ADDR_TIME_HIGH     = 16'hED10;
  localparam logic [15:0] ADDR_ALARM_LOW     = 16'hED12;
  localparam logic [15:0] ADDR_ALARM_HIGH    = 16'hED14;

  // clock_control field positions
  localparam int SWITCH_OFF_BIT   = 7;
  localparam int ALARM_EN_BIT     = 3;
  localparam int ALARM_FLAG_BIT   = 2;
  localparam int TICK_EN_BIT      = 1;
  localparam int TICK_FLAG_BIT    = 0;

  // clock_control reset value
  localparam logic [15:0] CLOCK_CONTROL_RESET = 16'h0000;

  // fixed pre-divider: last count of the divide-by-64 stage
  localparam logic [5:0]  PRE_DIV_LAST = 6'h3F;

  // widths of the divider, of the high prescale part and of the time count
  localparam int PRESCALE_W    = 20;
  localparam int PRESCALE_HI_W = 4;
  localparam int TIME_W        = 32;
endpackage : rtc_pkg

/* File: rtc_divider.sv */
`timescale 1ns/1ps
module rtc_divider
  import rtc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  run,       // dividers may count
  input  wire logic                  load,      // preload divider
  input  wire logic [PRESCALE_W-1:0] prescale,  // reload value
  output logic                       tickPulse, // basic reference tick
  output logic [PRESCALE_W-1:0]      divCount_r // divider contents
);

  // divider state
  typedef struct packed {
    logic [5:0]            pre; // divide-by-64 stage
    logic [PRESCALE_W-1:0] div; // 20-bit down counter, not reset
  } div_state_t;

  div_state_t st_r;  // registered state
  div_state_t st_nxt; // next state
  logic       preWrap; // pre-divider terminal count

  // next state of both stages
  always_comb begin
    st_nxt  = st_r;
    preWrap = run && (st_r.pre == PRE_DIV_LAST); // [R1]
    // tick as the divider reaches its end and reloads
    tickPulse = preWrap && (st_r.div <= 20'h00001); // [R3] [R21]
    if (run) begin
      st_nxt.pre = st_r.pre + 6'h01; // [R1]
    end
    if (load) begin
      // new prescale value goes straight into the divider
      st_nxt.div = prescale;
    end else if (tickPulse) begin
      st_nxt.div = prescale; // [R2]
    end else if (preWrap) begin
      st_nxt.div = st_r.div - 20'h00001; // [R3]
    end
  end

  // registers; the divider keeps its value through reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.pre <= 6'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign divCount_r = st_r.div;

  // reload after each tick
  property p_reload;
    @(posedge clk) disable iff (!rst_n)
      (tickPulse && !load) |=> (st_r.div == $past(prescale));
  endproperty
  a_reload: assert property (p_reload) // [R2]
    else $error("divider not reloaded at tick");

  // tick only on a pre-divider wrap
  property p_prewrap;
    @(posedge clk) disable iff (!rst_n)
      tickPulse |-> (st_r.pre == PRE_DIV_LAST) && run;
  endproperty
  a_prewrap: assert property (p_prewrap) // [R1]
    else $error("tick outside pre-divider wrap");

endmodule : rtc_divider

/* File: rtc_prescaler_counter_alarm_bench.sv */
`timescale 1ns/1ps
module rtc_prescaler_counter_alarm_bench;
  import rtc_pkg::*;

  logic        clk;                 // core clock
  logic        rst_n;               // async reset, active low
  logic [15:0] busAddr;             // register byte address
  logic        busWrite;            // write strobe
  logic        busRead;             // read strobe
  logic [15:0] busWdata;            // write data
  logic [15:0] busRdata_r;          // read data
  logic        powerDown;           // chip in power-down
  logic        standBy;             // chip in stand-by
  logic        powerdownWakeConfig; // wake allowed
  logic        tickRequest_r;       // tick request pulse
  logic        alarmRequest_r;      // alarm request pulse
  logic        oscStop_r;           // oscillator off
  logic        wakeRequest_r;       // wake pulse
  int          failures;            // mismatches seen
  int          comparisons;         // compares made
  logic [15:0] rd;                  // scratch read value
  int          n;                   // cycles waited

  rtc_prescaler_counter_alarm rtc_prescaler_counter_alarm_i (
    .clk                 (clk),
    .rst_n               (rst_n),
    .busAddr             (busAddr),
    .busWrite            (busWrite),
    .busRead             (busRead),
    .busWdata            (busWdata),
    .busRdata_r          (busRdata_r),
    .powerDown           (powerDown),
    .standBy             (standBy),
    .powerdownWakeConfig (powerdownWakeConfig),
    .tickRequest_r       (tickRequest_r),
    .alarmRequest_r      (alarmRequest_r),
    .oscStop_r           (oscStop_r),
    .wakeRequest_r       (wakeRequest_r)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare one value, count and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask : check

  // one-cycle word write, driven at the falling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    busAddr  = a;
    busWdata = d;
    busWrite = 1'b1;
    @(negedge clk);
    busWrite = 1'b0;
  endtask : wr

  // one-cycle word read, data settled one edge later
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    busAddr = a;
    busRead = 1'b1;
    @(negedge clk);
    busRead = 1'b0;
    d = busRdata_r;
  endtask : rd_reg

  // bounded wait for a pulse: 0 tick, 1 alarm, 2 wake, 3 tick or alarm
  task automatic wait_req(input int sel, input int bound, output int cnt);
    logic hit;
    cnt = 0;
    for (int i = 1; i <= bound; i++) begin
      @(negedge clk);
      case (sel)
        0:       hit = tickRequest_r;
        1:       hit = alarmRequest_r;
        2:       hit = wakeRequest_r;
        default: hit = tickRequest_r | alarmRequest_r;
      endcase
      if (hit === 1'b1) begin
        cnt = i;
        return;
      end
    end
  endtask : wait_req

  // verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    rst_n = 1'b0;
    busAddr = 16'h0000;
    busWrite = 1'b0;
    busRead = 1'b0;
    busWdata = 16'h0000;
    powerDown = 1'b0;
    standBy = 1'b0;
    powerdownWakeConfig = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd_reg(ADDR_CLOCK_CONTROL, rd);
    check(rd, CLOCK_CONTROL_RESET, "control reset");
    rd_reg(16'hED02, rd);
    check(rd, 16'h0000, "unmapped read");
    // stop the clock and program prescale, time and alarm
    wr(ADDR_CLOCK_CONTROL, 16'h0080);
    wr(ADDR_PRESCALE_LOW, 16'h0002);
    wr(ADDR_PRESCALE_HIGH, 16'hFFF0);
    rd_reg(ADDR_PRESCALE_HIGH, rd);
    check(rd, 16'h0000, "prescale high");
    rd_reg(ADDR_PRESCALE_LOW, rd);
    check(rd, 16'h0002, "prescale low");
    // divider loaded from prescale while stopped
    rd_reg(ADDR_DIVIDER_LOW, rd);
    check(rd, 16'h0002, "divider low loaded");
    rd_reg(ADDR_DIVIDER_HIGH, rd);
    check(rd, 16'h0000, "divider high loaded");
    wr(ADDR_TIME_LOW, 16'hFFFF);
    wr(ADDR_TIME_HIGH, 16'h0001);
    wr(ADDR_ALARM_LOW, 16'h0002);
    wr(ADDR_ALARM_HIGH, 16'h0002);
    rd_reg(ADDR_TIME_LOW, rd);
    check(rd, 16'hFFFF, "time preload");
    // run with both requests enabled
    wr(ADDR_CLOCK_CONTROL, 16'h000A);
    wait_req(0, 300, n);
    check(16'(n != 0), 16'h0001, "first tick");
    // measured from the first tick, no bus traffic in between
    wait_req(0, 300, n);
    check(16'(n), 16'd128, "tick period");
    rd_reg(ADDR_TIME_HIGH, rd);
    check(rd, 16'h0002, "time carry high");
    rd_reg(ADDR_TIME_LOW, rd);
    check(rd, 16'h0001, "time carry low");
    wait_req(1, 200, n);
    check(16'(n != 0), 16'h0001, "alarm seen");
    rd_reg(ADDR_TIME_LOW, rd);
    check(rd, 16'h0002, "time at alarm");
    wait_req(1, 100, n);
    check(16'(n), 16'h0000, "single alarm");
    rd_reg(ADDR_CLOCK_CONTROL, rd);
    check(rd, 16'h000F, "flags set");
    // disabled requests: flags still set, no pulses
    wait_req(0, 300, n);
    rd_reg(ADDR_TIME_LOW, rd);
    wr(ADDR_ALARM_LOW, rd + 16'h0001);
    wr(ADDR_CLOCK_CONTROL, 16'h0005);
    wait_req(3, 140, n);
    check(16'(n), 16'h0000, "requests gated");
    rd_reg(ADDR_CLOCK_CONTROL, rd);
    check(rd, 16'h0005, "flags without enable");
    // stand-by halts counting; time protected while running
    standBy = 1'b1;
    rd_reg(ADDR_TIME_LOW, rd);
    n = int'(rd);
    wr(ADDR_TIME_LOW, 16'h1234);
    repeat (140) @(negedge clk);
    rd_reg(ADDR_TIME_LOW, rd);
    check(rd, 16'(n), "time frozen");
    standBy = 1'b0;
    // power-down with switch-off stops the oscillator
    wr(ADDR_CLOCK_CONTROL, 16'h0082);
    powerDown = 1'b1;
    repeat (2) @(negedge clk);
    check({15'h0000, oscStop_r}, 16'h0001, "osc stop");
    wr(ADDR_CLOCK_CONTROL, 16'h0002);
    repeat (2) @(negedge clk);
    check({15'h0000, oscStop_r}, 16'h0000, "osc runs");
    wait_req(2, 140, n);
    check(16'(n), 16'h0000, "wake blocked");
    powerdownWakeConfig = 1'b1;
    wait_req(2, 200, n);
    check(16'(n != 0), 16'h0001, "wake seen");
    powerDown = 1'b0;
    powerdownWakeConfig = 1'b0;
    // prescale protected while running
    wr(ADDR_PRESCALE_LOW, 16'h0007);
    rd_reg(ADDR_PRESCALE_LOW, rd);
    check(rd, 16'h0002, "prescale protected");
    // prescale survives a reset, control does not
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_reg(ADDR_PRESCALE_LOW, rd);
    check(rd, 16'h0002, "prescale kept");
    rd_reg(ADDR_CLOCK_CONTROL, rd);
    check(rd, CLOCK_CONTROL_RESET, "control cleared");
    give_verdict();
  end
endmodule : rtc_prescaler_counter_alarm_bench
